// ===== irqsf_pkg.sv
// Constants for the interrupt source flag pair
package irqsf_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int ADDR_W = 16;
	localparam logic [15:0] ADDR_RX_TX_STATUS = 16'h00f5;
	localparam logic [15:0] ADDR_PHY_EVENTS = 16'h00f6;

	// ----------------------------------------------------------------
	// Bit positions, first register
	// ----------------------------------------------------------------
	localparam int BIT_FRAME_TX_DONE = 7;
	localparam int BIT_RX_LEVEL = 6;
	localparam int BIT_MODE_SWITCH_RX_DONE = 5;
	localparam int BIT_RX_OVERRUN = 4;
	localparam int BIT_ADDR_FILTER = 3;
	localparam int BIT_FRAME_LENGTH = 2;
	localparam int BIT_RX_BANK1_DONE = 1;
	localparam int BIT_RX_BANK0_DONE = 0;

	// ----------------------------------------------------------------
	// Bit positions, second register
	// ----------------------------------------------------------------
	localparam int BIT_PREAMBLE_FOUND = 7;
	localparam int BIT_CCA_DONE = 6;
	localparam int BIT_AGC_DONE = 5;
	localparam int BIT_RX_BYTE_COUNT = 4;
	localparam int BIT_FRAME_RX_DONE = 3;
	localparam int BIT_RX_START = 2;
	localparam int BIT_TX_START = 1;
	localparam int BIT_TX_BYTE_COUNT = 0;

	// ----------------------------------------------------------------
	// Auto-clear masks and reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] CANCEL_MASK_RX_TX = 8'h0f;
	localparam logic [7:0] CANCEL_MASK_PHY = 8'hb4;
	localparam logic [7:0] DONE_MASK_RX_TX = 8'h0c;
	localparam logic [7:0] DONE_MASK_PHY = 8'hb4;
	localparam logic [7:0] FLAG_RESET = 8'h00;
	localparam logic [7:0] RDATA_RESET = 8'h00;
	localparam logic IRQ_RESET = 1'b0;

endpackage : irqsf_pkg

// ===== irqsf_flags.sv
// Clear-on-read interrupt source flag registers, first and second
//
// Functional notes
// R1 - Enabled event sets its flag; disabled never
// R2 - Read clears only bits read as one
// R3 - Writes ignored; host clears by dummy reads
// R4 - Host reads all eight bytes in one frame
// R5 - Flag reset value is undefined for users
// R6 - First register at 00F5H, upper four bits
// R7 - First register lower four bits layout
// R8 - Second register at 00F6H, upper four bits
// R9 - Second register lower four bits layout
// R10 - Zero means none, one means request pending
// R11 - Polarity select inverts interrupt output level
// R12 - Cancel auto-clear wipes reception flags
// R13 - Completion auto-clear wipes associated flags
// R14 - Interrupt asserted while any flag set
`timescale 1ns/1ps
module irqsf_flags (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Register read port from the serial decoder
	input wire logic regRead,
	input wire logic [15:0] regAddr,
	output logic [7:0] regRdata,
	// Event pulses and their enables
	input wire logic [7:0] eventRxTx,
	input wire logic [7:0] enableRxTx,
	input wire logic [7:0] eventPhy,
	input wire logic [7:0] enablePhy,
	// Reception auto-clear triggers and mode bits
	input wire logic rxCancel,
	input wire logic rxDone,
	input wire logic cancel_autoclear_en,
	input wire logic rx_done_autoclear_en,
	input wire logic irq_polarity_sel,
	// Interrupt pin
	output logic irq_output_pin
);

	// ----------------------------------------------------------------
	// Flag update
	// ----------------------------------------------------------------
	// Set always beats any clear in the same cycle, so no event is lost
	function automatic logic [7:0] flagNext(
		input logic [7:0] cur,
		input logic [7:0] setV,
		input logic [7:0] clrV
	);
		flagNext = (cur & ~clrV) | setV;
	endfunction : flagNext

	logic [7:0] flagsRxTx_r;
	logic [7:0] flagsPhy_r;
	logic [7:0] flagsRxTx_nxt;
	logic [7:0] flagsPhy_nxt;
	logic [7:0] regRdata_r;
	logic [7:0] regRdata_nxt;
	logic irqOut_r;
	logic irqOut_nxt;

	wire logic hitRxTx = regRead && (regAddr == irqsf_pkg::ADDR_RX_TX_STATUS);
	wire logic hitPhy = regRead && (regAddr == irqsf_pkg::ADDR_PHY_EVENTS);
	wire logic cancelClr = rxCancel && cancel_autoclear_en;
	wire logic doneClr = rxDone && rx_done_autoclear_en;
	// Gated events only; no write path exists into the flags
	wire logic [7:0] setRxTx = eventRxTx & enableRxTx; // see R1 see R3
	wire logic [7:0] setPhy = eventPhy & enablePhy; // see R1
	// Reading clears exactly the ones that were returned
	wire logic [7:0] rdClrRxTx = hitRxTx ? flagsRxTx_r : 8'h00; // see R2
	wire logic [7:0] rdClrPhy = hitPhy ? flagsPhy_r : 8'h00; // see R2
	wire logic [7:0] autoClrRxTx =
		(cancelClr ? irqsf_pkg::CANCEL_MASK_RX_TX : 8'h00) | // see R12
		(doneClr ? irqsf_pkg::DONE_MASK_RX_TX : 8'h00); // see R13
	wire logic [7:0] autoClrPhy =
		(cancelClr ? irqsf_pkg::CANCEL_MASK_PHY : 8'h00) | // see R12
		(doneClr ? irqsf_pkg::DONE_MASK_PHY : 8'h00); // see R13

	assign flagsRxTx_nxt = flagNext(flagsRxTx_r, setRxTx,
		rdClrRxTx | autoClrRxTx); // see R10
	assign flagsPhy_nxt = flagNext(flagsPhy_r, setPhy,
		rdClrPhy | autoClrPhy); // see R10

	// Data of an unmapped address reads as zero
	assign regRdata_nxt = hitRxTx ? flagsRxTx_r : // see R6 see R7
		hitPhy ? flagsPhy_r : 8'h00; // see R8 see R9
	// Pin follows the next flag state so it drops with the clearing read
	assign irqOut_nxt = ((|flagsRxTx_nxt) || (|flagsPhy_nxt)) ^
		irq_polarity_sel; // see R11 see R14

	// ----------------------------------------------------------------
	// Named flag bits
	// ----------------------------------------------------------------
	// Only the checks read these; the datapath works on whole bytes
	wire logic frame_tx_done_flag =
		flagsRxTx_r[irqsf_pkg::BIT_FRAME_TX_DONE]; // see R6
	wire logic rx_level_flag =
		flagsRxTx_r[irqsf_pkg::BIT_RX_LEVEL]; // see R6
	wire logic mode_switch_rx_done_flag =
		flagsRxTx_r[irqsf_pkg::BIT_MODE_SWITCH_RX_DONE]; // see R6
	wire logic rx_overrun_flag =
		flagsRxTx_r[irqsf_pkg::BIT_RX_OVERRUN]; // see R6
	wire logic addr_filter_flag =
		flagsRxTx_r[irqsf_pkg::BIT_ADDR_FILTER]; // see R7
	wire logic frame_length_flag =
		flagsRxTx_r[irqsf_pkg::BIT_FRAME_LENGTH]; // see R7
	wire logic rx_bank1_done_flag =
		flagsRxTx_r[irqsf_pkg::BIT_RX_BANK1_DONE]; // see R7
	wire logic rx_bank0_done_flag =
		flagsRxTx_r[irqsf_pkg::BIT_RX_BANK0_DONE]; // see R7
	wire logic preamble_found_flag =
		flagsPhy_r[irqsf_pkg::BIT_PREAMBLE_FOUND]; // see R8
	wire logic cca_done_flag =
		flagsPhy_r[irqsf_pkg::BIT_CCA_DONE]; // see R8
	wire logic agc_done_flag =
		flagsPhy_r[irqsf_pkg::BIT_AGC_DONE]; // see R8
	wire logic rx_byte_count_flag =
		flagsPhy_r[irqsf_pkg::BIT_RX_BYTE_COUNT]; // see R8
	wire logic frame_rx_done_flag =
		flagsPhy_r[irqsf_pkg::BIT_FRAME_RX_DONE]; // see R9
	wire logic rx_start_flag =
		flagsPhy_r[irqsf_pkg::BIT_RX_START]; // see R9
	wire logic tx_start_flag =
		flagsPhy_r[irqsf_pkg::BIT_TX_START]; // see R9
	wire logic tx_byte_count_flag =
		flagsPhy_r[irqsf_pkg::BIT_TX_BYTE_COUNT]; // see R9

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	// Reset value is a convenience only; users must not rely on it
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flagsRxTx_r <= irqsf_pkg::FLAG_RESET; // see R5
			flagsPhy_r <= irqsf_pkg::FLAG_RESET;
		end else begin
			flagsRxTx_r <= flagsRxTx_nxt;
			flagsPhy_r <= flagsPhy_nxt;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata_r <= irqsf_pkg::RDATA_RESET;
			irqOut_r <= irqsf_pkg::IRQ_RESET;
		end else begin
			regRdata_r <= regRdata_nxt;
			irqOut_r <= irqOut_nxt;
		end
	end

	assign regRdata = regRdata_r;
	assign irq_output_pin = irqOut_r;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_set_takes_effect: assert property ( // see R1
		(|setRxTx) |=> ((flagsRxTx_r & $past(setRxTx)) == $past(setRxTx)))
		else $error("enabled event did not set its flag");

	a_no_spurious_set: assert property ( // see R1
		##1 ((flagsPhy_r & ~$past(flagsPhy_r) & ~$past(setPhy)) == 8'h00))
		else $error("flag rose without an enabled event");

	a_read_clears_ones: assert property ( // see R2
		hitRxTx |=> ((flagsRxTx_r & $past(flagsRxTx_r) & ~$past(setRxTx))
			== 8'h00))
		else $error("read did not clear the ones it returned");

	a_idle_keeps_flags: assert property ( // see R2
		(!hitPhy && !cancelClr && !doneClr) |=>
			(($past(flagsPhy_r) & ~flagsPhy_r) == 8'h00))
		else $error("flag fell without read or auto-clear");

	a_read_first_data: assert property ( // see R6
		hitRxTx |=> (regRdata_r == $past(flagsRxTx_r)))
		else $error("first register read data wrong");

	a_read_second_data: assert property ( // see R8
		hitPhy |=> (regRdata_r == $past(flagsPhy_r)))
		else $error("second register read data wrong");

	a_unmapped_zero: assert property ( // see R6
		(regRead && !hitRxTx && !hitPhy) |=> (regRdata_r == 8'h00))
		else $error("unmapped read not zero");

	a_irq_level_follows: assert property ( // see R14
		##1 (irq_output_pin == (((|flagsRxTx_r) || (|flagsPhy_r)) ^
			$past(irq_polarity_sel))))
		else $error("interrupt pin level wrong");

	a_cancel_wipes: assert property ( // see R12
		cancelClr |=> ((flagsPhy_r & irqsf_pkg::CANCEL_MASK_PHY &
			~$past(setPhy)) == 8'h00))
		else $error("cancel auto-clear left a flag set");

	a_done_wipes: assert property ( // see R13
		doneClr |=> ((flagsRxTx_r & irqsf_pkg::DONE_MASK_RX_TX &
			~$past(setRxTx)) == 8'h00))
		else $error("completion auto-clear left a flag set");

	a_set_phy_flags: assert property ( // see R1
		(|setPhy) |=> ((flagsPhy_r & $past(setPhy)) == $past(setPhy)))
		else $error("enabled event did not set its flag");

	a_no_spurious_rxtx: assert property ( // see R1
		##1 ((flagsRxTx_r & ~$past(flagsRxTx_r) & ~$past(setRxTx))
			== 8'h00))
		else $error("flag rose without an enabled event");

	a_disabled_quiet: assert property ( // see R1
		((setRxTx == 8'h00) && (setPhy == 8'h00)) |=>
			(((flagsRxTx_r & ~$past(flagsRxTx_r)) == 8'h00) &&
			((flagsPhy_r & ~$past(flagsPhy_r)) == 8'h00)))
		else $error("flag set while its event was off");

	// ----------------------------------------------------------------
	// Checks, clearing
	// ----------------------------------------------------------------
	a_read_clears_phy: assert property ( // see R2
		hitPhy |=> ((flagsPhy_r & $past(flagsPhy_r) & ~$past(setPhy))
			== 8'h00))
		else $error("read did not clear the ones it returned");

	a_idle_keeps_rxtx: assert property ( // see R2 see R3
		(!hitRxTx && !cancelClr && !doneClr) |=>
			(($past(flagsRxTx_r) & ~flagsRxTx_r) == 8'h00))
		else $error("flag fell without read or auto-clear");

	a_read_keeps_rxtx: assert property ( // see R2
		(hitRxTx && (|setRxTx)) |=>
			((flagsRxTx_r & $past(setRxTx)) == $past(setRxTx)))
		else $error("event during read was lost");

	a_read_keeps_phy: assert property ( // see R2
		(hitPhy && (|setPhy)) |=>
			((flagsPhy_r & $past(setPhy)) == $past(setPhy)))
		else $error("event during read was lost");

	a_cancel_wipes_rxtx: assert property ( // see R12
		cancelClr |=> ((flagsRxTx_r & irqsf_pkg::CANCEL_MASK_RX_TX &
			~$past(setRxTx)) == 8'h00))
		else $error("cancel auto-clear left a flag set");

	a_done_wipes_phy: assert property ( // see R13
		doneClr |=> ((flagsPhy_r & irqsf_pkg::DONE_MASK_PHY &
			~$past(setPhy)) == 8'h00))
		else $error("completion auto-clear left a flag set");

	a_cancel_spares_rxtx: assert property ( // see R12
		(!hitRxTx && cancelClr && !doneClr) |=> (($past(flagsRxTx_r) &
			~flagsRxTx_r & ~irqsf_pkg::CANCEL_MASK_RX_TX) == 8'h00))
		else $error("cancel auto-clear wiped an unrelated flag");

	a_cancel_spares_phy: assert property ( // see R12
		(!hitPhy && cancelClr && !doneClr) |=> (($past(flagsPhy_r) &
			~flagsPhy_r & ~irqsf_pkg::CANCEL_MASK_PHY) == 8'h00))
		else $error("cancel auto-clear wiped an unrelated flag");

	a_done_spares_rxtx: assert property ( // see R13
		(!hitRxTx && doneClr && !cancelClr) |=> (($past(flagsRxTx_r) &
			~flagsRxTx_r & ~irqsf_pkg::DONE_MASK_RX_TX) == 8'h00))
		else $error("completion auto-clear wiped an unrelated flag");

	a_done_spares_phy: assert property ( // see R13
		(!hitPhy && doneClr && !cancelClr) |=> (($past(flagsPhy_r) &
			~flagsPhy_r & ~irqsf_pkg::DONE_MASK_PHY) == 8'h00))
		else $error("completion auto-clear wiped an unrelated flag");

	// ----------------------------------------------------------------
	// Checks, read data and pin
	// ----------------------------------------------------------------
	a_first_layout: assert property ( // see R6 see R7
		hitRxTx |=> (regRdata_r == $past({frame_tx_done_flag,
			rx_level_flag, mode_switch_rx_done_flag, rx_overrun_flag,
			addr_filter_flag, frame_length_flag, rx_bank1_done_flag,
			rx_bank0_done_flag})))
		else $error("first register bit layout wrong");

	a_second_layout: assert property ( // see R8 see R9
		hitPhy |=> (regRdata_r == $past({preamble_found_flag,
			cca_done_flag, agc_done_flag, rx_byte_count_flag,
			frame_rx_done_flag, rx_start_flag, tx_start_flag,
			tx_byte_count_flag})))
		else $error("second register bit layout wrong");

	a_rdata_idle_zero: assert property ( // see R6 see R8
		!regRead |=> (regRdata_r == 8'h00))
		else $error("read data not zero without a read");

	a_pin_pending: assert property ( // see R11 see R14
		##1 (!((|flagsRxTx_r) || (|flagsPhy_r)) ||
			(irq_output_pin != $past(irq_polarity_sel))))
		else $error("pending flag not shown on the pin");

	a_pin_quiet: assert property ( // see R11 see R14
		##1 ((|flagsRxTx_r) || (|flagsPhy_r) ||
			(irq_output_pin == $past(irq_polarity_sel))))
		else $error("pin shows a request with no flag set");

endmodule : irqsf_flags

// ===== irqsf_host.sv
// Host model reading the flag group over the register port
`timescale 1ns/1ps
module irqsf_host (
	// Clock
	input wire logic clk,
	// Register read port
	output logic regRead,
	output logic [15:0] regAddr,
	input wire logic [7:0] regRdata
);
	initial begin
		regRead = 1'b0;
		regAddr = 16'h0000;
	end
	// All eight bytes in one unbroken burst, never a write
	task automatic readGroup(output logic [63:0] d);
		for (int i = 0; i < 9; i++) begin
			@(posedge clk);
			regRead <= (i < 8);
			regAddr <= 16'h00f4 + 16'(i);
			#1;
			if (i > 0)
				d[8*i-8 +: 8] = regRdata;
		end
	endtask : readGroup
endmodule : irqsf_host

// ===== irq_source_flags_1_2_tb.sv
// Self-checking bench for the interrupt source flag pair
`timescale 1ns/1ps
module irq_source_flags_1_2_tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic rxCancel = 1'b0;
	logic rxDone = 1'b0;
	logic cancelEn = 1'b0;
	logic doneEn = 1'b0;
	logic polSel = 1'b0;
	logic [7:0] evA = 8'h00, enA = 8'h00, evB = 8'h00, enB = 8'h00;
	logic regRead, irqPin;
	logic [15:0] regAddr;
	logic [7:0] regRdata;
	logic [63:0] g;
	int mismatches = 0;
	int checked = 0;
	int cycles = 0;
	always #12.5 clk = ~clk;
	irqsf_flags u_irqsf_flags (.clk(clk), .rst_n(rst_n),
		.regRead(regRead), .regAddr(regAddr), .regRdata(regRdata),
		.eventRxTx(evA), .enableRxTx(enA), .eventPhy(evB),
		.enablePhy(enB), .rxCancel(rxCancel), .rxDone(rxDone),
		.cancel_autoclear_en(cancelEn), .rx_done_autoclear_en(doneEn),
		.irq_polarity_sel(polSel), .irq_output_pin(irqPin));
	irqsf_host u_irqsf_host (.clk(clk), .regRead(regRead),
		.regAddr(regAddr), .regRdata(regRdata));
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	// Group image: unmapped bytes read as zero
	function automatic logic [63:0] grp(input logic [7:0] a, b);
		return {40'h0, b, a, 8'h00};
	endfunction : grp
	task automatic pulse(input logic [7:0] a, b, ea, eb, input logic c, d);
		@(posedge clk);
		evA <= a;
		evB <= b;
		enA <= ea;
		enB <= eb;
		rxCancel <= c;
		rxDone <= d;
		@(posedge clk);
		evA <= 8'h00;
		evB <= 8'h00;
		rxCancel <= 1'b0;
		rxDone <= 1'b0;
		#1;
	endtask : pulse
	task automatic report_and_stop();
		if (mismatches == 0 && checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : report_and_stop
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			report_and_stop();
		end
	end
	initial begin
		logic [15:0] m;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		// Flush whatever reset left, value unknown
		u_irqsf_host.readGroup(g);
		check(64'(irqPin), 64'h0);
		for (int b = 0; b < 16; b++) begin
			m = 16'h0001 << b;
			pulse(m[7:0], m[15:8], 8'hff, 8'hff, 1'b0, 1'b0);
			check(64'(irqPin), 64'h1);
			u_irqsf_host.readGroup(g);
			check(g, grp(m[7:0], m[15:8]));
			check(64'(irqPin), 64'h0);
			u_irqsf_host.readGroup(g);
			check(g, 64'h0);
		end
		pulse(8'hff, 8'hff, 8'h00, 8'h00, 1'b0, 1'b0);
		u_irqsf_host.readGroup(g);
		check(g, 64'h0);
		// Event lands on the very edge that reads its flag
		pulse(8'h01, 8'h00, 8'hff, 8'hff, 1'b0, 1'b0);
		fork
			u_irqsf_host.readGroup(g);
			begin
				repeat (2) @(posedge clk);
				evA <= 8'h03;
				@(posedge clk);
				evA <= 8'h00;
			end
		join
		check(g, grp(8'h01, 8'h00));
		u_irqsf_host.readGroup(g);
		check(g, grp(8'h03, 8'h00));
		@(posedge clk);
		polSel <= 1'b1;
		pulse(8'h00, 8'h08, 8'hff, 8'hff, 1'b0, 1'b0);
		check(64'(irqPin), 64'h0);
		u_irqsf_host.readGroup(g);
		check(64'(irqPin), 64'h1);
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			cancelEn <= k[1];
			doneEn <= k[1];
			pulse(8'hff, 8'hff, 8'hff, 8'hff, 1'b0, 1'b0);
			pulse(8'h00, 8'h00, 8'hff, 8'hff, !k[0], k[0]);
			u_irqsf_host.readGroup(g);
			check(g, k[1] ? grp(k[0] ? 8'hf3 : 8'hf0, 8'h4b)
				: grp(8'hff, 8'hff));
		end
		report_and_stop();
	end
endmodule : irq_source_flags_1_2_tb
